/* rtl/frame_sync_pkg.sv */
package frame_sync_pkg;
	localparam int          ADDR_W         = 3;
	localparam int          DATA_W         = 16;
	localparam int          CNT_W          = 16;
	localparam logic [2:0]  OFS_CONTROL    = 3'h0;
	localparam logic [2:0]  OFS_LOWER      = 3'h1;
	localparam logic [2:0]  OFS_UPPER      = 3'h2;
	localparam logic [2:0]  OFS_STATE      = 3'h3;
	localparam logic [2:0]  OFS_CHANGE     = 3'h4;
	localparam logic [2:0]  OFS_IRQ_EN     = 3'h5;
	localparam int          POS_HITMISS    = 0;
	localparam int          POS_HOLD       = 2;
	localparam int          POS_SPLIT      = 3;
	localparam int          POS_WINDOW     = 4;
	localparam logic [15:0] RST_CONTROL    = 16'h0000;
	localparam logic [15:0] RST_OFFSET     = 16'h0000;
	localparam logic [15:0] CONTROL_MASK   = 16'h00FF;
	// Frame length in byte clock cycles until a pulse spacing is first measured
	localparam logic [15:0] FRAME_LEN_DFLT = 16'h2000;

	typedef enum logic [2:0] {
		ST_HUNT  = 3'b001,
		ST_OUT   = 3'b010,
		ST_IN    = 3'b100
	} fly_state_t;
endpackage

/* rtl/sync_input.sv */
`timescale 1ns/100ps
module sync_input (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic pin,
	output logic      rise
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign rise = sync_reg & ~last_reg;
endmodule

/* rtl/offset_sync_gen.sv */
`timescale 1ns/100ps
module offset_sync_gen (
	input  wire logic                             clk,
	input  wire logic                             arst_n,
	input  wire logic [frame_sync_pkg::CNT_W-1:0] phase,
	input  wire logic [frame_sync_pkg::CNT_W-1:0] offset,
	output logic                                  frame_sync
);
	import frame_sync_pkg::*;

	// One-cycle pulse in the cycle after the frame phase equals the offset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			frame_sync <= 1'b0;
		end else begin
			frame_sync <= (phase == offset);
		end
	end
endmodule

/* rtl/frame_sync_manager.sv */
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module frame_sync_manager (
	input  wire logic                              clk,
	input  wire logic                              arst_n,
	input  wire logic                              ext_sync,
	input  wire logic [frame_sync_pkg::ADDR_W-1:0] addr,
	input  wire logic [frame_sync_pkg::DATA_W-1:0] wdata,
	input  wire logic                              wr,
	input  wire logic                              rd,
	output logic      [frame_sync_pkg::DATA_W-1:0] rdata,
	output logic                                   lower_frame_sync,
	output logic                                   upper_frame_sync,
	output logic                                   irq
);
	import frame_sync_pkg::*;

	logic [15:0]      control_reg;
	logic [15:0]      lower_reg;
	logic [15:0]      upper_reg;
	logic             change_reg;
	logic             irq_en_reg;
	logic             in_sync_reg;
	logic [15:0]      shown_lower_reg;
	logic [15:0]      shown_upper_reg;
	logic [15:0]      phase_reg;
	logic [15:0]      frame_len_reg;
	logic [15:0]      meas_reg;
	logic [2:0]       count_reg;
	logic             seen_reg;
	fly_state_t       state_reg;

	logic             pulse;
	logic [1:0]       hit_miss_count;
	logic             flywheel_hold;
	logic             split_domain_select;
	logic [3:0]       jitter_tolerance_window;
	logic [16:0]      dist_fwd;
	logic [16:0]      dist_back;
	logic             in_window;
	logic             window_end;
	logic             hit;
	logic             miss;
	logic [2:0]       needed;
	logic             enter_sync;
	logic             leave_sync;
	logic             change_set;
	logic             change_read;
	logic [15:0]      upper_used;

	////////////////////////////////////////////////////////////////////////
	sync_input u_sync_input (
		.clk    (clk),
		.arst_n (arst_n),
		.pin    (ext_sync),
		.rise   (pulse)
	);

	assign hit_miss_count          = control_reg[POS_HITMISS +: 2];
	assign flywheel_hold           = control_reg[POS_HOLD];
	assign split_domain_select     = control_reg[POS_SPLIT];
	assign jitter_tolerance_window = control_reg[POS_WINDOW +: 4];

	assign needed = {1'b0, hit_miss_count} + 3'h1;

	// distance from the predicted frame start, both directions
	assign dist_fwd  = {1'b0, phase_reg};
	assign dist_back = {1'b0, frame_len_reg} - {1'b0, phase_reg};
	assign in_window = (dist_fwd <= {13'h0000, jitter_tolerance_window})
		|| (dist_back <= {13'h0000, jitter_tolerance_window});
	assign window_end = (phase_reg == {12'h000, jitter_tolerance_window});
	assign hit  = pulse && in_window && (state_reg != ST_HUNT);
	assign miss = window_end && !seen_reg && !pulse && (state_reg != ST_HUNT);

	assign enter_sync = !in_sync_reg && hit && (count_reg + 3'h1 >= needed);
	assign leave_sync = in_sync_reg && miss && (count_reg + 3'h1 >= needed);

	////////////////////////////////////////////////////////////////////////
	// Flywheel phase counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_reg <= 16'h0000;
		end else if (pulse && !flywheel_hold
			&& (state_reg == ST_HUNT || (state_reg == ST_OUT && !in_window)))
		begin
			// realign on a new pulse position
			// Pulse cycle is phase zero, so a zero window means exact
			phase_reg <= 16'h0001;
		end else if (phase_reg >= frame_len_reg - 16'h0001) begin
			phase_reg <= 16'h0000;
		end else begin
			phase_reg <= phase_reg + 16'h0001;
		end
	end

	// Frame length learned from pulse spacing
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meas_reg      <= 16'h0000;
			frame_len_reg <= FRAME_LEN_DFLT;
		end else if (pulse) begin
			meas_reg <= 16'h0001;
			if (!flywheel_hold && !in_sync_reg && meas_reg > 16'h0001) begin
				frame_len_reg <= meas_reg;
			end
		end else if (meas_reg != 16'hFFFF && meas_reg != 16'h0000) begin
			meas_reg <= meas_reg + 16'h0001;
		end
	end

	// Pulse seen in the current window
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seen_reg <= 1'b0;
		end else if (window_end) begin
			seen_reg <= 1'b0;
		end else if (hit) begin
			seen_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Hit/miss state machine
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg   <= ST_HUNT;
			count_reg   <= 3'h0;
			in_sync_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_HUNT: begin
					if (pulse) begin
						state_reg <= ST_OUT;
						count_reg <= 3'h0;
					end
				end
				ST_OUT: begin
					if (enter_sync) begin
						state_reg   <= ST_IN;
						in_sync_reg <= 1'b1;
						count_reg   <= 3'h0;
					end else if (hit) begin
						count_reg <= count_reg + 3'h1;
					end else if (miss || (pulse && !in_window)) begin
						count_reg <= 3'h0;
					end
				end
				ST_IN: begin
					if (leave_sync) begin
						state_reg   <= ST_OUT;
						in_sync_reg <= 1'b0;
						count_reg   <= 3'h0;
					end else if (miss) begin
						count_reg <= count_reg + 3'h1;
					end else if (hit) begin
						count_reg <= 3'h0;
					end
				end
				default: begin
					state_reg   <= ST_HUNT;
					count_reg   <= 3'h0;
					in_sync_reg <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Offsets applied to the on-chip syncs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shown_lower_reg <= RST_OFFSET;
			shown_upper_reg <= RST_OFFSET;
		end else if (enter_sync || !in_sync_reg) begin
			shown_lower_reg <= lower_reg;
			shown_upper_reg <= upper_used;
		end
	end

	assign upper_used = split_domain_select ? upper_reg : lower_reg;

	offset_sync_gen u_lower_gen (
		.clk        (clk),
		.arst_n     (arst_n),
		.phase      (phase_reg),
		.offset     (shown_lower_reg),
		.frame_sync (lower_frame_sync)
	);

	offset_sync_gen u_upper_gen (
		.clk        (clk),
		.arst_n     (arst_n),
		.phase      (phase_reg),
		.offset     (shown_upper_reg),
		.frame_sync (upper_frame_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			control_reg <= RST_CONTROL;
			lower_reg   <= RST_OFFSET;
			upper_reg   <= RST_OFFSET;
			irq_en_reg  <= 1'b0;
		end else if (wr) begin
			case (addr)
				OFS_CONTROL: control_reg <= wdata & CONTROL_MASK;
				OFS_LOWER:   lower_reg   <= wdata;
				OFS_UPPER:   upper_reg   <= wdata;
				OFS_IRQ_EN:  irq_en_reg  <= wdata[0];
				default: begin
				end
			endcase
		end
	end

	assign change_set  = enter_sync || leave_sync;
	assign change_read = rd && (addr == OFS_CHANGE);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			change_reg <= 1'b0;
		end else if (change_set) begin
			change_reg <= 1'b1;
		end else if (change_read) begin
			change_reg <= 1'b0;
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			case (addr)
				OFS_CONTROL: rdata <= control_reg & CONTROL_MASK;
				OFS_LOWER:   rdata <= lower_reg;
				OFS_UPPER:   rdata <= upper_reg;
				OFS_STATE:   rdata <= {15'h0000, in_sync_reg};
				OFS_CHANGE:  rdata <= {15'h0000, change_reg};
				OFS_IRQ_EN:  rdata <= {15'h0000, irq_en_reg};
				default:     rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end

	assign irq = change_reg & irq_en_reg;
endmodule

/* sim/frame_sync_monitor.sv */
`timescale 1ns/100ps
module frame_sync_monitor (
	input wire logic                              clk,
	input wire logic                              arst_n,
	input wire logic [frame_sync_pkg::ADDR_W-1:0] addr,
	input wire logic [frame_sync_pkg::DATA_W-1:0] wdata,
	input wire logic                              wr,
	input wire logic                              rd,
	input wire logic [frame_sync_pkg::DATA_W-1:0] rdata,
	input wire logic                              lower_frame_sync,
	input wire logic                              upper_frame_sync,
	input wire logic                              irq
);
	import frame_sync_pkg::*;
	logic en_reg;
	wire  rd_chg = rd && addr == OFS_CHANGE;
	wire  en_wr  = wr && addr == OFS_IRQ_EN;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////////////
	// Mirror of the interrupt enable as software wrote it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			en_reg <= 1'b0;
		else if (en_wr)
			en_reg <= wdata[0];
	end
	////////////////////////////////////////////////////////////////////////
	a_idle_read_zero: assert property (!rd |=> rdata == '0)
		else $error("rdata not zero outside read");
	a_control_high_zero: assert property (
		rd && addr == OFS_CONTROL |=> rdata[15:8] == 8'h00)
		else $error("control upper byte not zero");
	a_invalid_read_zero: assert property (
		rd && addr[2:1] == 2'b11 |=> rdata == '0)
		else $error("invalid offset not zero");
	a_state_one_bit: assert property (
		rd && (addr == OFS_STATE || rd_chg) |=> rdata[15:1] == '0)
		else $error("status upper bits not zero");
	a_irq_needs_enable: assert property (
		irq |-> en_reg || $past(en_reg))
		else $error("irq while disabled");
	a_irq_change_read: assert property (irq && rd_chg |=> rdata[0])
		else $error("irq without change bit");
	a_irq_fall_cause: assert property (
		$fell(irq) |-> $past(rd_chg) || $past(en_wr) || $past(en_wr, 2))
		else $error("irq dropped without read or disable");
	a_pulse_one_cycle: assert property (
		lower_frame_sync |=> !lower_frame_sync)
		else $error("frame sync pulse too long");
	a_upper_one_cycle: assert property (
		upper_frame_sync |=> !upper_frame_sync)
		else $error("upper frame sync pulse too long");
	c_irq_rise: cover property ($rose(irq));
	c_frame_pulse: cover property (lower_frame_sync);
	c_change_read: cover property (irq && rd_chg);
endmodule
bind frame_sync_manager frame_sync_monitor mon (.clk, .arst_n, .addr,
	.wdata, .wr, .rd, .rdata, .lower_frame_sync, .upper_frame_sync, .irq);

/* sim/sync_pulse_source.sv */
`timescale 1ns/100ps
module sync_pulse_source (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        run,
	input  wire logic [15:0] period,
	output logic             pulse
);
	logic [15:0] cnt_reg;
	// Frame counter keeps running while quiet so restarts stay on grid
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 16'h0000;
			pulse   <= 1'b0;
		end else begin
			cnt_reg <= (cnt_reg >= period - 16'h0001) ? 16'h0000
				: cnt_reg + 16'h0001;
			pulse   <= run && cnt_reg == 16'h0000;
		end
	end
endmodule

/* sim/testbench.sv */
`timescale 1ns/100ps
module testbench;
	import frame_sync_pkg::*;
	localparam int P = 200;
	logic        clk, arst_n, ext_sync, wr, rd, run, lo_fs, up_fs, irq;
	logic [2:0]  addr;
	logic [15:0] wdata, rdata, d, v, period;
	logic [15:0] m [8];
	logic [31:0] seed;
	int          failures, compares, cyc, last_lo, last_up, k, k0;
	sync_pulse_source src (.clk, .arst_n, .run, .period, .pulse(ext_sync));
	frame_sync_manager uut (.clk, .arst_n, .ext_sync, .addr, .wdata, .wr,
		.rd, .rdata, .lower_frame_sync(lo_fs), .upper_frame_sync(up_fs), .irq);
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (lo_fs === 1'b1) last_lo = cyc;
		if (up_fs === 1'b1) last_up = cyc;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [15:0] keep(input logic [2:0] a,
		input logic [15:0] x, o);
		case (a)
			OFS_CONTROL: return x & CONTROL_MASK;
			OFS_LOWER, OFS_UPPER: return x;
			OFS_IRQ_EN: return x & 16'h0001;
			default: return o;
		endcase
	endfunction
	task automatic chk(input string n, input logic [15:0] s, e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [2:0] a,
		input logic [15:0] x);
		@(posedge clk);
		addr <= a;
		wdata <= x;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		// Read data stand in the cycle after the strobe
		@(posedge clk);
		d = rdata;
	endtask
	task automatic lock(input logic [15:0] c);
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		bus(1, OFS_CONTROL, c);
		// Offsets are frozen while in sync, so they go in first
		bus(1, OFS_LOWER, 16'h0005);
		bus(1, OFS_UPPER, 16'h000C);
		run <= 1'b1;
		k = 0;
		d = 16'h0000;
		while (d !== 16'h0001 && k < 12) begin
			@(posedge ext_sync);
			repeat (20) @(posedge clk);
			bus(0, OFS_STATE, 16'h0000);
			k++;
		end
	endtask
	task automatic test_done;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		test_done;
	end
	initial begin
		{clk, arst_n, addr, wdata, wr, rd, run} = '0;
		period = 16'(P);
		seed = 32'h00633B1C;
		foreach (m[i]) m[i] = 16'h0000;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			seed = lfsr(seed);
			v = seed[31:16];
			bus(1, seed[2:0], v);
			m[seed[2:0]] = keep(seed[2:0], v, m[seed[2:0]]);
			bus(0, seed[4:2], 16'h0000);
			chk("reg", d, m[seed[4:2]]);
		end
		$display("test registers done");
		for (int n = 0; n < 4; n++) begin
			lock(16'h0020 | 16'(n % 2 * 8 + n));
			if (n == 0) k0 = k;
			chk("hits", 16'(k - k0), 16'(n));
			chk("state", d, 16'h0001);
			bus(1, OFS_IRQ_EN, 16'h0001);
			chk("irq", 16'(irq), 16'h0001);
			bus(0, OFS_CHANGE, 16'h0000);
			chk("change", d, 16'h0001);
			bus(0, OFS_CHANGE, 16'h0000);
			chk("cleared", d | 16'(irq), 16'h0000);
			repeat (P + 20) @(posedge clk);
			chk("offset", 16'(last_up - last_lo), 16'(n % 2 * 7));
			@(posedge ext_sync);
			run <= 1'b0;
			repeat (n * P + P / 2) @(posedge clk);
			bus(0, OFS_STATE, 16'h0000);
			chk("flywheel", d, 16'h0001);
			repeat (P) @(posedge clk);
			bus(0, OFS_STATE, 16'h0000);
			chk("misses", d, 16'h0000);
			bus(1, OFS_IRQ_EN, 16'h0000);
			chk("masked", 16'(irq), 16'h0000);
			bus(0, OFS_CHANGE, 16'h0000);
			chk("lost", d, 16'h0001);
		end
		$display("test flywheel done");
		lock(16'h0020);
		for (int s = 2; s < 4; s++) begin
			bus(0, OFS_CHANGE, 16'h0000);
			@(posedge ext_sync);
			period <= 16'(P + s);
			@(posedge ext_sync);
			period <= 16'(P - s);
			// One late pulse, then back on the original grid
			@(posedge ext_sync);
			period <= 16'(P);
			repeat (20) @(posedge clk);
			bus(0, OFS_CHANGE, 16'h0000);
			chk("jitter", d, 16'(s > 2));
		end
		$display("test jitter done");
		lock(16'h0024);
		chk("hold", d, 16'h0000);
		$display("test hold done");
		test_done;
	end
endmodule
